/* File: include/i2c_regs_defs.vh */
// Register map, field positions, reset values and bus constants of the two-wire controller.
`ifndef I2C_REGS_DEFS_VH
`define I2C_REGS_DEFS_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define REG_CTRL   8'h00
`define REG_STAT   8'h04
`define REG_DATA   8'h08
`define REG_OWN    8'h0C
`define REG_CTRL2  8'h10
`define REG_DIV    8'h14
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CT_ON      7
`define CT_IRQ     6
`define CT_MST     5
`define CT_TX      4
`define CT_ACK     3
`define CT_REPEATED_START_REQ    2
`define SR_DONE    7
`define SR_HIT     6
`define SR_BUSY    5
`define SR_ARB     4
`define SR_SDIR    2
`define SR_IRQ     1
`define SR_ACKS    0
`define C2_GC      7
`define C2_TEN     6
// ----------------------------------------
// Reset values
// ----------------------------------------
`define CTRL_RST   8'h00
`define OWN_RST    8'hA0
`define CTRL2_RST  8'h00
`define DIV_RST    8'h3F
// ----------------------------------------
// Bus constants
// ----------------------------------------
`define BIT_LAST   4'h7
`define BIT_ACK    4'h8
`define TEN_PREFIX 5'h1E
`define GC_ADDR    7'h00
`define PH_LOW     2'h0
`define PH_RISE    2'h1
`define PH_HIGH    2'h2
`define PH_FALL    2'h3
`define RESP_OK    2'h0
`define RESP_ERR   2'h2
`endif

/* File: hdl/pin_sync.v */
// Two flip-flop synchroniser for asynchronous pin levels.
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter W = 2
) (
  // Clock and reset.
  input  wire         clock_in,
  input  wire         reset_in,
  // Raw and synchronised levels.
  input  wire [W-1:0] level_in,
  output reg  [W-1:0] level_out
);

  reg [W-1:0] stage;

  // Idle bus lines are high, so both stages reset high.
  always @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      stage     <= {W{1'b1}};
      level_out <= {W{1'b1}};
    end else begin
      stage     <= level_in;
      level_out <= stage;
    end
  end

endmodule
`default_nettype wire

/* File: hdl/bus_cond_detect.v */
// Start, stop and clock edge detection on the synchronised bus lines.
`timescale 1ns/10ps
`default_nettype none
module bus_cond_detect (
  // Clock and reset.
  input  wire clock_in,
  input  wire reset_in,
  // Synchronised line levels.
  input  wire scl_in,
  input  wire sda_in,
  // One-cycle events.
  output wire start_out,
  output wire stop_out,
  output wire scl_rise_out,
  output wire scl_fall_out
);

  reg scl_prev;
  reg sda_prev;

  // Previous levels; both lines idle high.
  always @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= scl_in;
      sda_prev <= sda_in;
    end
  end

  // Data may only change with the clock high at a start or a stop.
  assign start_out    = scl_in & scl_prev & sda_prev & ~sda_in;
  assign stop_out     = scl_in & scl_prev & ~sda_prev & sda_in;
  assign scl_rise_out = scl_in & ~scl_prev;
  assign scl_fall_out = ~scl_in & scl_prev;

endmodule
`default_nettype wire

/* File: hdl/i2c_master_slave_regs.v */
// Two-wire bus controller, master or slave, with its register file on AXI4-Lite.
//
// Behaviour
// - Control bit 7 enables the whole unit; zero holds it idle.
// - Control bit 6 allows the interrupt request; zero suppresses it.
// - Master select rising makes a start; falling makes a stop, back to slave.
// - Control bit 4 selects transmit or receive; set it for address cycles.
// - Receivers drive control bit 3 in the acknowledge slot; zero acknowledges.
// - Writing control bit 2 repeats a start only as master; reads zero.
// - A repeated start at a wrong moment counts as lost arbitration.
// - Status bit 7 sets at byte end; cleared by data access in mode.
// - Status bit 6 sets on address match or general call; control write clears.
// - Status bit 5 sets on any start and clears on any stop.
// - Status bit 4 sets on lost arbitration; cleared by writing one.
// - Status bit 2 holds the direction bit of the matched calling address.
// - Status bit 1 sets on byte end, match or lost arbitration; write one clears.
// - Status bit 0 shows the acknowledge sampled after a sent byte.
// - In master transmit, a data write sends the byte, msb first.
// - In master receive, each data read starts the next byte.
// - A matched slave starts bytes by data access as a master does.
// - Only a data access matching the direction starts a transfer.
// - Data reads return the last received byte.
// - The first byte after master select holds address and direction.
// - Second control bit 7 enables answering the general call address.
// - Second control bit 6 selects ten-bit own addressing.
`timescale 1ns/10ps
`default_nettype none
`include "i2c_regs_defs.vh"
module i2c_master_slave_regs (
  // Clock and reset.
  input  wire        clock_in,
  input  wire        reset_in,
  // AXI4-Lite write address channel.
  input  wire        axi_awvalid_in,
  output wire        axi_awready_out,
  input  wire [7:0]  axi_awaddr_in,
  // AXI4-Lite write data channel.
  input  wire        axi_wvalid_in,
  output wire        axi_wready_out,
  input  wire [31:0] axi_wdata_in,
  input  wire [3:0]  axi_wstrb_in,
  // AXI4-Lite write response channel.
  output reg         axi_bvalid_out,
  input  wire        axi_bready_in,
  output reg  [1:0]  axi_bresp_out,
  // AXI4-Lite read address channel.
  input  wire        axi_arvalid_in,
  output wire        axi_arready_out,
  input  wire [7:0]  axi_araddr_in,
  // AXI4-Lite read data channel.
  output reg         axi_rvalid_out,
  input  wire        axi_rready_in,
  output reg  [31:0] axi_rdata_out,
  output reg  [1:0]  axi_rresp_out,
  // Open-drain bus pins.
  input  wire        scl_in,
  output wire        scl_out,
  output reg         scl_oe_out,
  input  wire        sda_in,
  output wire        sda_out,
  output reg         sda_oe_out,
  // Interrupt request.
  output wire        irq_out
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [8:0] ST_IDLE  = 9'h001;
  localparam [8:0] ST_START = 9'h002;
  localparam [8:0] ST_MHOLD = 9'h004;
  localparam [8:0] ST_MBIT  = 9'h008;
  localparam [8:0] ST_REPEATED_START_REQ  = 9'h010;
  localparam [8:0] ST_STOP  = 9'h020;
  localparam [8:0] ST_SADDR = 9'h040;
  localparam [8:0] ST_SDATA = 9'h080;
  localparam [8:0] ST_SHOLD = 9'h100;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg        aw_full;
  reg        w_full;
  reg  [7:0] aw_addr;
  reg  [7:0] w_byte;
  reg        w_lane0;
  reg        unit_on;
  reg        irq_allow;
  reg        master_select;
  reg        tx_mode;
  reg        ack_drive_ctrl;
  reg        transfer_done_flag;
  reg        own_address_hit;
  reg        bus_busy;
  reg        arbitration_lost_flag;
  reg        slave_direction;
  reg        irq_pending;
  reg        ack_sampled;
  reg  [7:0] own_addr;
  reg        general_call_on;
  reg        ten_bit_addressing;
  reg  [2:0] addr_high;
  reg  [7:0] scl_div;
  reg  [7:0] rx_byte;
  reg  [7:0] tx_hold;
  reg        go_pend;
  reg  [8:0] state;
  reg  [1:0] phase;
  reg  [7:0] div_cnt;
  reg  [3:0] bit_n;
  reg  [7:0] shift;
  reg        samp;
  reg        slave_sel;
  reg        ten_stage;
  reg        ack_on;
  reg        next_scl_low;
  reg        next_sda_low;
  reg        bit_sda_low;
  reg  [7:0] rd_value;
  wire [1:0] line_s;
  wire       scl_s;
  wire       sda_s;
  wire       start_det;
  wire       stop_det;
  wire       scl_rise;
  wire       scl_fall;

  // ----------------------------------------
  // Pin synchronisers and bus conditions
  // ----------------------------------------
  pin_sync #(.W(2)) u_sync (
    .clock_in  (clock_in),
    .reset_in  (reset_in),
    .level_in  ({scl_in, sda_in}),
    .level_out (line_s)
  );
  assign scl_s = line_s[1];
  assign sda_s = line_s[0];

  bus_cond_detect u_cond (
    .clock_in     (clock_in),
    .reset_in     (reset_in),
    .scl_in       (scl_s),
    .sda_in       (sda_s),
    .start_out    (start_det),
    .stop_out     (stop_det),
    .scl_rise_out (scl_rise),
    .scl_fall_out (scl_fall)
  );

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  // Each address and data channel is taken on its own; the write runs once both are held.
  wire wr_go = aw_full & w_full & ~axi_bvalid_out;
  wire rd_go = axi_arvalid_in & ~axi_rvalid_out;
  wire [7:0] wa = {aw_addr[7:2], 2'b00};
  wire [7:0] ra = {axi_araddr_in[7:2], 2'b00};
  wire wr_hit = wr_go & w_lane0;
  wire wr_ctrl = wr_hit & (wa == `REG_CTRL);
  wire wr_stat = wr_hit & (wa == `REG_STAT);
  wire wr_data = wr_hit & (wa == `REG_DATA);
  wire rd_data = rd_go & (ra == `REG_DATA);
  wire wa_ok = (wa == `REG_CTRL) | (wa == `REG_STAT) | (wa == `REG_DATA) |
               (wa == `REG_OWN) | (wa == `REG_CTRL2) | (wa == `REG_DIV);
  wire ra_ok = (ra == `REG_CTRL) | (ra == `REG_STAT) | (ra == `REG_DATA) |
               (ra == `REG_OWN) | (ra == `REG_CTRL2) | (ra == `REG_DIV);
  // A trigger only counts when the access matches the direction.
  wire trig = (wr_data & tx_mode) | (rd_data & ~tx_mode);

  assign axi_awready_out = ~aw_full;
  assign axi_wready_out  = ~w_full;
  assign axi_arready_out = ~axi_rvalid_out;

  // Channel holding registers and responses.
  always @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      aw_full        <= 1'b0;
      w_full         <= 1'b0;
      aw_addr        <= 8'h00;
      w_byte         <= 8'h00;
      w_lane0        <= 1'b0;
      axi_bvalid_out <= 1'b0;
      axi_bresp_out  <= `RESP_OK;
      axi_rvalid_out <= 1'b0;
      axi_rdata_out  <= 32'h00000000;
      axi_rresp_out  <= `RESP_OK;
    end else begin
      if (axi_awvalid_in && !aw_full) begin
        aw_full <= 1'b1;
        aw_addr <= axi_awaddr_in;
      end else if (wr_go) begin
        aw_full <= 1'b0;
      end
      if (axi_wvalid_in && !w_full) begin
        w_full  <= 1'b1;
        w_byte  <= axi_wdata_in[7:0];
        w_lane0 <= axi_wstrb_in[0];
      end else if (wr_go) begin
        w_full <= 1'b0;
      end
      if (wr_go) begin
        axi_bvalid_out <= 1'b1;
        axi_bresp_out  <= wa_ok ? `RESP_OK : `RESP_ERR;
      end else if (axi_bready_in) begin
        axi_bvalid_out <= 1'b0;
      end
      if (rd_go) begin
        axi_rvalid_out <= 1'b1;
        axi_rdata_out  <= {24'h000000, rd_value};
        axi_rresp_out  <= ra_ok ? `RESP_OK : `RESP_ERR;
      end else if (axi_rready_in) begin
        axi_rvalid_out <= 1'b0;
      end
    end
  end

  // Read multiplexer; unmapped and reserved bits read zero.
  always @* begin
    case (ra)
      `REG_CTRL:  rd_value = {unit_on, irq_allow, master_select, tx_mode,
                              ack_drive_ctrl, 3'b000};
      `REG_STAT:  rd_value = {transfer_done_flag, own_address_hit, bus_busy,
                              arbitration_lost_flag, 1'b0, slave_direction,
                              irq_pending, ack_sampled};
      `REG_DATA:  rd_value = rx_byte;
      `REG_OWN:   rd_value = {own_addr[7:1], 1'b0};
      `REG_CTRL2: rd_value = {general_call_on, ten_bit_addressing, 3'b000, addr_high};
      `REG_DIV:   rd_value = scl_div;
      default:    rd_value = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Bit clock generation
  // ----------------------------------------
  wire m_active = |(state & (ST_START | ST_MBIT | ST_REPEATED_START_REQ | ST_STOP));
  // While the clock is released but still low, another device stretches it.
  wire stall = ~scl_oe_out & ~scl_s;
  wire tick = m_active & ~stall & (div_cnt == scl_div);

  always @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      div_cnt <= 8'h00;
    end else if (!m_active || tick) begin
      div_cnt <= 8'h00;
    end else if (!stall) begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  // ----------------------------------------
  // Address match
  // ----------------------------------------
  wire [7:0] byte_now = {shift[6:0], samp};
  wire gc_hit = general_call_on & (byte_now[7:1] == `GC_ADDR);
  wire seven_hit = ~ten_bit_addressing & (byte_now[7:1] == own_addr[7:1]);
  wire ten_first = ten_bit_addressing & ~ten_stage &
                   (byte_now[7:3] == `TEN_PREFIX) & (byte_now[2:1] == addr_high[2:1]);
  wire ten_hit = ten_stage & (byte_now == {addr_high[0], own_addr[7:1]});
  wire addr_hit = gc_hit | seven_hit | ten_hit;

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  // Data slot drive, shared by master and slave since the unit is never both.
  always @* begin
    bit_sda_low = 1'b0;
    if (state == ST_SADDR) begin
      bit_sda_low = (bit_n == `BIT_ACK) & ack_on;
    end else if (bit_n != `BIT_ACK) begin
      bit_sda_low = tx_mode & ~shift[7];
    end else begin
      bit_sda_low = ~tx_mode & ~ack_drive_ctrl;
    end
  end

  // Line levels per state and quarter phase.
  always @* begin
    next_scl_low = 1'b0;
    next_sda_low = 1'b0;
    case (state)
      ST_START: begin
        next_sda_low = (phase != `PH_LOW);
        next_scl_low = (phase == `PH_FALL);
      end
      ST_MHOLD, ST_SHOLD: begin
        next_scl_low = 1'b1;
      end
      ST_MBIT: begin
        next_scl_low = (phase == `PH_LOW) | (phase == `PH_FALL);
        next_sda_low = bit_sda_low;
      end
      ST_REPEATED_START_REQ: begin
        next_scl_low = (phase == `PH_LOW) | (phase == `PH_FALL);
        next_sda_low = phase[1];
      end
      ST_STOP: begin
        next_scl_low = (phase == `PH_LOW);
        next_sda_low = ~phase[1];
      end
      ST_SADDR, ST_SDATA: begin
        next_sda_low = bit_sda_low;
      end
      default: begin
        next_scl_low = 1'b0;
      end
    endcase
  end

  // Open-drain outputs are registered so the pins never glitch.
  always @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      scl_oe_out <= 1'b0;
      sda_oe_out <= 1'b0;
    end else begin
      scl_oe_out <= next_scl_low & unit_on;
      sda_oe_out <= next_sda_low & unit_on;
    end
  end
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign irq_out = irq_pending & irq_allow;

  // ----------------------------------------
  // Registers and transfer engine
  // ----------------------------------------
  // Clears come first in this process so that a same-cycle set wins.
  always @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      {unit_on, irq_allow, master_select, tx_mode, ack_drive_ctrl} <= 5'h00;
      transfer_done_flag    <= 1'b0;
      own_address_hit       <= 1'b0;
      bus_busy              <= 1'b0;
      arbitration_lost_flag <= 1'b0;
      slave_direction       <= 1'b0;
      irq_pending           <= 1'b0;
      ack_sampled           <= 1'b0;
      own_addr              <= `OWN_RST;
      {general_call_on, ten_bit_addressing, addr_high} <= 5'h00;
      scl_div               <= `DIV_RST;
      rx_byte               <= 8'h00;
      tx_hold               <= 8'h00;
      go_pend               <= 1'b0;
      state                 <= ST_IDLE;
      phase                 <= `PH_LOW;
      bit_n                 <= 4'h0;
      shift                 <= 8'h00;
      samp                  <= 1'b1;
      slave_sel             <= 1'b0;
      ten_stage             <= 1'b0;
      ack_on                <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        unit_on         <= w_byte[`CT_ON];
        irq_allow       <= w_byte[`CT_IRQ];
        master_select   <= w_byte[`CT_MST];
        tx_mode         <= w_byte[`CT_TX];
        ack_drive_ctrl  <= w_byte[`CT_ACK];
        own_address_hit <= 1'b0;
        // Claiming a busy bus, or a repeat start outside a held master byte, loses.
        if ((w_byte[`CT_MST] && !master_select && bus_busy) ||
            (w_byte[`CT_REPEATED_START_REQ] && !(state == ST_MHOLD && w_byte[`CT_MST]))) begin
          arbitration_lost_flag <= 1'b1;
          irq_pending           <= 1'b1;
          master_select         <= 1'b0;
        end
      end
      if (wr_stat && w_byte[`SR_ARB]) arbitration_lost_flag <= 1'b0;
      if (wr_stat && w_byte[`SR_IRQ]) irq_pending <= 1'b0;
      if (wr_hit && wa == `REG_OWN) own_addr <= w_byte;
      if (wr_hit && wa == `REG_CTRL2) begin
        general_call_on    <= w_byte[`C2_GC];
        ten_bit_addressing <= w_byte[`C2_TEN];
        addr_high          <= w_byte[2:0];
      end
      if (wr_hit && wa == `REG_DIV) scl_div <= w_byte;
      if (trig) begin
        transfer_done_flag <= 1'b0;
        go_pend            <= 1'b1;
      end
      if (wr_data) tx_hold <= w_byte;
      if (start_det) bus_busy <= 1'b1;
      if (stop_det) bus_busy <= 1'b0;
      if (tick) phase <= phase + 2'h1;

      case (state)
        ST_IDLE: begin
          // A pending byte has no meaning without a held transfer.
          if (!trig) go_pend <= 1'b0;
          if (unit_on && master_select && !bus_busy) begin
            state <= ST_START;
            phase <= `PH_LOW;
          end
        end
        ST_START, ST_REPEATED_START_REQ: begin
          if (tick && phase == `PH_FALL) state <= ST_MHOLD;
        end
        ST_MHOLD: begin
          phase <= `PH_LOW;
          bit_n <= 4'h0;
          if (!master_select) begin
            state <= ST_STOP;
          end else if (wr_ctrl && w_byte[`CT_REPEATED_START_REQ]) begin
            state <= ST_REPEATED_START_REQ;
          end else if (go_pend) begin
            go_pend <= 1'b0;
            shift   <= tx_hold;
            state   <= ST_MBIT;
          end
        end
        ST_MBIT: begin
          if (tick && phase == `PH_HIGH) begin
            samp <= sda_s;
            if (bit_n == `BIT_ACK && tx_mode) ack_sampled <= sda_s;
            // Sending a one while the line reads zero means another master won.
            if (bit_n != `BIT_ACK && tx_mode && shift[7] && !sda_s) begin
              arbitration_lost_flag <= 1'b1;
              irq_pending           <= 1'b1;
              master_select         <= 1'b0;
              state                 <= ST_IDLE;
            end
          end
          if (tick && phase == `PH_FALL) begin
            if (bit_n != `BIT_ACK) begin
              shift <= byte_now;
              bit_n <= bit_n + 4'h1;
            end else begin
              transfer_done_flag <= 1'b1;
              irq_pending        <= 1'b1;
              if (!tx_mode) rx_byte <= shift;
              state <= ST_MHOLD;
            end
          end
        end
        ST_STOP: begin
          if (tick && phase == `PH_FALL) state <= ST_IDLE;
        end
        ST_SADDR, ST_SDATA: begin
          if (scl_rise) begin
            samp <= sda_s;
            if (state == ST_SDATA && bit_n == `BIT_ACK && tx_mode) ack_sampled <= sda_s;
          end
          if (scl_fall && bit_n != `BIT_ACK) begin
            shift <= byte_now;
            bit_n <= bit_n + 4'h1;
            if (state == ST_SADDR && bit_n == `BIT_LAST) begin
              if (addr_hit) begin
                own_address_hit <= 1'b1;
                irq_pending     <= 1'b1;
                slave_sel       <= 1'b1;
                ack_on          <= 1'b1;
                if (!ten_stage) slave_direction <= byte_now[0];
              end else if (ten_first) begin
                ack_on          <= 1'b1;
                slave_direction <= byte_now[0];
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          if (scl_fall && bit_n == `BIT_ACK) begin
            bit_n  <= 4'h0;
            ack_on <= 1'b0;
            if (state == ST_SADDR && !slave_sel) begin
              ten_stage <= 1'b1;
            end else if (state == ST_SADDR) begin
              transfer_done_flag <= 1'b1;
              state              <= ST_SHOLD;
            end else begin
              transfer_done_flag <= 1'b1;
              irq_pending        <= 1'b1;
              if (!tx_mode) rx_byte <= shift;
              // A refused byte from the master ends the slave transmission.
              state <= (tx_mode && samp) ? ST_IDLE : ST_SHOLD;
            end
          end
        end
        ST_SHOLD: begin
          bit_n <= 4'h0;
          if (go_pend) begin
            go_pend <= 1'b0;
            shift   <= tx_hold;
            state   <= ST_SDATA;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase

      // A start seen in idle or a slave state while not mastering opens a fresh address phase.
      if (start_det && !master_select &&
          (state == ST_IDLE || state == ST_SADDR || state == ST_SDATA || state == ST_SHOLD)) begin
        state     <= ST_SADDR;
        bit_n     <= 4'h0;
        slave_sel <= 1'b0;
        ten_stage <= 1'b0;
        ack_on    <= 1'b0;
      end
      if (stop_det && (state == ST_SADDR || state == ST_SDATA || state == ST_SHOLD)) begin
        state     <= ST_IDLE;
        slave_sel <= 1'b0;
      end
      if (!unit_on) begin
        state   <= ST_IDLE;
        go_pend <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

/* File: tb/i2c_regs_assertions.sv */
// Checker of bus answers and pin behaviour of the two-wire controller.
`timescale 1ns/10ps
`default_nettype none
module i2c_regs_assertions (
  // Watched ports; grouped by type to keep the list short.
  input wire logic clock_in, reset_in, axi_awvalid_in, axi_awready_out, axi_wvalid_in,
  input wire logic axi_wready_out, axi_bvalid_out, axi_bready_in, axi_arvalid_in,
  input wire logic axi_arready_out, axi_rvalid_out, axi_rready_in, scl_oe_out, sda_oe_out,
  input wire logic irq_out,
  input wire logic [1:0] axi_bresp_out, axi_rresp_out,
  input wire logic [3:0] axi_wstrb_in,
  input wire logic [7:0] axi_awaddr_in, axi_araddr_in,
  input wire logic [31:0] axi_wdata_in, axi_rdata_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  // Writes counted only when both channels meet in one cycle, as the bench offers them.
  wire wgo = axi_awvalid_in && axi_awready_out && axi_wvalid_in && axi_wready_out;
  wire cgo = wgo && axi_awaddr_in == 8'h00 && axi_wstrb_in[0];
  a_write_resp: assert property (wgo |-> ##2 axi_bvalid_out &&
    axi_bresp_out == ($past(axi_awaddr_in, 2) > 8'h17 ? 2'h2 : 2'h0)) else $error("bad bresp");
  a_resp_holds: assert property (axi_bvalid_out && !axi_bready_in |=> axi_bvalid_out &&
    $stable(axi_bresp_out)) else $error("bresp dropped");
  a_read_resp: assert property (axi_arvalid_in && axi_arready_out |=> axi_rvalid_out &&
    axi_rresp_out == ($past(axi_araddr_in) > 8'h17 ? 2'h2 : 2'h0)) else $error("bad rresp");
  a_data_holds: assert property (axi_rvalid_out && !axi_rready_in |=> axi_rvalid_out &&
    $stable(axi_rdata_out)) else $error("rdata dropped");
  a_read_blocks: assert property (axi_rvalid_out |-> !axi_arready_out) else $error("ar open");
  a_upper_zero: assert property (axi_rvalid_out |-> axi_rdata_out[31:8] == 0)
    else $error("upper bits set");
  a_irq_masked: assert property (cgo && !axi_wdata_in[6] |-> ##2 !irq_out)
    else $error("irq not masked");
  a_unit_off: assert property (cgo && !axi_wdata_in[7] |->
    ##[1:4] (!scl_oe_out && !sda_oe_out)) else $error("pins held");
endmodule
bind i2c_master_slave_regs i2c_regs_assertions i_i2c_regs_assertions (.*);
`default_nettype wire

/* File: tb/bus_slave_model.sv */
// Bus slave model: acknowledges each byte and keeps the last one.
`timescale 1ns/10ps
`default_nettype none
module bus_slave_model (
  // Resolved lines in, acknowledge drive and byte out.
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output var  logic       ack_oe_out = 0,
  output var  logic [7:0] byte_out
);
  int n = 0;
  // A start restarts the bit count.
  always @(negedge sda_in) if (scl_in) n = 0;
  // Bits are taken on the rising clock; the ninth rise closes the byte.
  always @(posedge scl_in) begin
    if (n == 8) n = 0;
    else begin
      byte_out <= {byte_out[6:0], sda_in};
      n++;
    end
  end
  // Data is pulled low from the eighth fall to the ninth to acknowledge.
  always @(negedge scl_in) ack_oe_out <= n == 8;
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Bench of the two-wire controller: registers, misplaced repeat, master transmit.
`timescale 1ns/10ps
`default_nettype none
`include "i2c_regs_defs.vh"
module testbench;
  logic clock_in = 0, reset_in = 1, axi_awvalid_in = 0, axi_wvalid_in = 0;
  logic axi_bready_in = 0, axi_arvalid_in = 0, axi_rready_in = 0;
  logic [3:0] axi_wstrb_in = 4'hF;
  logic [7:0] axi_awaddr_in = 0, axi_araddr_in = 0, got;
  logic [31:0] axi_wdata_in = 0, axi_rdata_out;
  logic [1:0] axi_bresp_out, axi_rresp_out;
  wire axi_awready_out, axi_wready_out, axi_bvalid_out, axi_arready_out, axi_rvalid_out;
  wire scl_out, sda_out, scl_oe_out, sda_oe_out, ack_oe, irq_out;
  // Open-drain lines with pull-ups.
  wire scl_in = !scl_oe_out;
  wire sda_in = !(sda_oe_out || ack_oe);
  int n_errors = 0, check_count = 0, cycles = 0;
  i2c_master_slave_regs i_i2c_master_slave_regs (.*);
  bus_slave_model i_bus_slave_model (.scl_in, .sda_in, .ack_oe_out(ack_oe), .byte_out(got));
  // Clock, and a ceiling that ends a hung run.
  always #12.5 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 8000) begin
      n_errors++;
      end_of_test;
    end
  end
  task automatic chk(input logic [9:0] s, e);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // Write one register; each channel is released once taken.
  task automatic wr(input logic [7:0] a, d);
    @(posedge clock_in);
    axi_awaddr_in <= a;
    axi_wdata_in <= {24'h0, d};
    axi_awvalid_in <= 1;
    axi_wvalid_in <= 1;
    do begin
      @(posedge clock_in);
      if (axi_awready_out) axi_awvalid_in <= 0;
      if (axi_wready_out) axi_wvalid_in <= 0;
      axi_bready_in <= axi_bvalid_out && !axi_bready_in;
    end while (!(axi_bvalid_out && axi_bready_in));
  endtask
  // Read one register as response and low byte.
  task automatic rd(input logic [7:0] a, output logic [9:0] v);
    @(posedge clock_in);
    axi_araddr_in <= a;
    axi_arvalid_in <= 1;
    do begin
      @(posedge clock_in);
      if (axi_arready_out) axi_arvalid_in <= 0;
      axi_rready_in <= axi_rvalid_out && !axi_rready_in;
    end while (!(axi_rvalid_out && axi_rready_in));
    v = {axi_rresp_out, axi_rdata_out[7:0]};
  endtask
  task automatic rc(input logic [7:0] a, input logic [9:0] e);
    logic [9:0] v;
    rd(a, v);
    chk(v, e);
  endtask
  // Polls a status bit; only the ceiling ends a wait that never comes.
  task automatic poll(input int b, input logic w);
    logic [9:0] v;
    do rd(`REG_STAT, v); while (v[b] !== w);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (8) @(posedge clock_in);
    reset_in <= 0;
    rc(`REG_CTRL, 10'h000);
    rc(`REG_STAT, 10'h000);
    rc(8'h18, 10'h200);
    wr(8'h18, 8'hFF);
    $display("reset test done");
    wr(`REG_CTRL, 8'h84);
    rc(`REG_CTRL, 10'h080);
    rc(`REG_STAT, 10'h012);
    wr(`REG_STAT, 8'h12);
    rc(`REG_STAT, 10'h000);
    $display("repeat test done");
    wr(`REG_DIV, 8'h04);
    wr(`REG_CTRL, 8'hB0);
    poll(`SR_BUSY, 1);
    wr(`REG_DATA, 8'hA2);
    poll(`SR_DONE, 1);
    rc(`REG_STAT, 10'h0A2);
    chk({2'h0, got}, 10'h0A2);
    wr(`REG_CTRL, 8'hF0);
    chk({9'h0, irq_out}, 10'h001);
    wr(`REG_STAT, 8'h02);
    chk({9'h0, irq_out}, 10'h000);
    wr(`REG_DATA, 8'h5C);
    rc(`REG_STAT, 10'h020);
    poll(`SR_DONE, 1);
    chk({2'h0, got}, 10'h05C);
    wr(`REG_CTRL, 8'hA0);
    rc(`REG_DATA, 10'h000);
    poll(`SR_DONE, 1);
    wr(`REG_CTRL, 8'hB0);
    rc(`REG_DATA, 10'h0FF);
    wr(`REG_CTRL, 8'h80);
    poll(`SR_BUSY, 0);
    wr(`REG_CTRL, 8'h00);
    $display("transmit test done");
    end_of_test;
  end
endmodule
`default_nettype wire
